//--- rtl/iscp_defines.svh
`ifndef ISCP_DEFINES_SVH
`define ISCP_DEFINES_SVH
`define ISCP_CH_BS     8'h08
`define ISCP_CH_CR     8'h0d
`define ISCP_CH_SP     8'h20
`define ISCP_CH_COMMA  8'h2c
`define ISCP_CH_GT     8'h3e
`define ISCP_LINE_LEN  80
`define ISCP_NRM_MAX   11
`define ISCP_FIFO_DEPTH 16
`define ISCP_LEN_W     7
`define ISCP_IDX_W     6
`define ISCP_E001_TXT  "E001 UNKNOWN COMMAND"
`define ISCP_E001_LEN  6'h14
`define ISCP_E002_TXT  "E002 INCORRECT NUMBER OF PARAMETERS"
`define ISCP_E002_LEN  6'h23
`define ISCP_TAIL_LEN  6'h02
`define ISCP_PROMPT_START 6'h01
`define ISCP_MAINT_WORD 88'h534552564943454d4f4445
`define ISCP_MAINT_WLEN 11
`define ISCP_TRIM_WORD  56'h42544f4d4f4445
`define ISCP_TRIM_WLEN  7
`endif

//--- rtl/iscp_pkg.sv
package iscp_pkg;
  typedef enum logic [1:0] {
    ISCP_DG_CONFIG = 2'h0,
    ISCP_DG_TRIM   = 2'h1,
    ISCP_DG_ERROR  = 2'h2
  } iscp_dgram_t;
  typedef enum logic [1:0] {
    ISCP_MODE_NORMAL = 2'h0,
    ISCP_MODE_MAINT  = 2'h1,
    ISCP_MODE_TRIM   = 2'h3
  } iscp_mode_t;
  typedef enum logic [2:0] {
    ISCP_ST_IDLE   = 3'h0,
    ISCP_ST_ECHO   = 3'h1,
    ISCP_ST_DECODE = 3'h3,
    ISCP_ST_MSG    = 3'h2,
    ISCP_ST_LIST   = 3'h6
  } iscp_state_t;
  typedef enum logic [1:0] {
    ISCP_MSG_PROMPT = 2'h0,
    ISCP_MSG_E001   = 2'h1,
    ISCP_MSG_E002   = 2'h2
  } iscp_msg_t;
  typedef struct packed {
    logic        valid;
    iscp_dgram_t kind;
  } iscp_special_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] letter;
    logic [6:0] len;
  } iscp_cmd_t;
endpackage

//--- rtl/iscp_fifo.sv
`timescale 1ns/1ps
module iscp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  logic             clock_i,
  input  logic             sys_rst_i,
  input  logic             in_valid_i,
  input  logic [WIDTH-1:0] in_data_i,
  output logic             in_ready_o,
  output logic             out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input  logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd;
  logic [AW-1:0]    wr;
  logic [AW:0]      cnt;
  logic [AW-1:0]    next_rd;
  logic [AW-1:0]    next_wr;
  logic [AW:0]      next_cnt;
  logic             do_push;
  logic             do_pop;

  assign in_ready_o  = (cnt != DEPTH[AW:0]);
  assign out_valid_o = (cnt != '0);
  assign out_data_o  = mem[rd];

  always_comb begin
    do_push  = in_valid_i && in_ready_o;
    do_pop   = out_valid_o && out_ready_i;
    next_wr  = do_push ? wr + 1'b1 : wr;
    next_rd  = do_pop ? rd + 1'b1 : rd;
    next_cnt = cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rd  <= '0;
      wr  <= '0;
      cnt <= '0;
    end else begin
      rd  <= next_rd;
      wr  <= next_wr;
      cnt <= next_cnt;
    end
    if (do_push) begin
      mem[wr] <= in_data_i;
    end
  end
endmodule

//--- rtl/iscp_top.sv
// Behaviour
// - Config request sends one datagram next slot
// - Special datagram may span several slots
// - External trigger mode uses trigger as slot
// - Trim request sends one offset datagram
// - Error request sends accumulated error datagram
// - Clear errors after error datagram ends
// - Reset command pulses full unit reset
// - Maintenance entry waits for datagram end
// - Maintenance entry starts identification listing
// - Trim mode entry waits for datagram end
// - Maintenance letters lower case, exact match
// - Parser knows the fifteen maintenance letters
// - Ready prompt is CR then greater-than
// - Maintenance mode echoes every character
// - Decode only on carriage return
// - Maintenance back-space removes last char since CR
// - Line buffer holds eighty characters
// - Space then commas separate parameters
// - Errors reply E, number, space, text, CR
// - Normal mode: no echo, exact CR command
// - Clear errors after start-up and report
`timescale 1ns/1ps
`include "iscp_defines.svh"
module iscp_top
  import iscp_pkg::*;
#(
  parameter int LINE_LEN   = `ISCP_LINE_LEN,
  parameter int FIFO_DEPTH = `ISCP_FIFO_DEPTH
) (
  input  logic          clock_i,
  input  logic          sys_rst_i,
  input  logic          rx_valid_i,
  input  logic [7:0]    rx_data_i,
  output logic          rx_ready_o,
  output logic          tx_valid_o,
  output logic [7:0]    tx_data_o,
  input  logic          tx_ready_i,
  input  logic          slot_i,
  input  logic          ext_trig_mode_i,
  input  logic          ext_trig_i,
  input  logic          dgram_busy_i,
  input  logic          dgram_done_i,
  input  logic          startup_done_i,
  input  logic          listing_done_i,
  input  logic          maint_exit_i,
  input  logic          trim_exit_i,
  output iscp_special_t special_o,
  output iscp_mode_t    mode_o,
  output logic          unit_reset_o,
  output logic          err_clear_o,
  output logic          listing_start_o,
  output iscp_cmd_t     maint_cmd_o
);
  logic [7:0]            mem [LINE_LEN];
  iscp_state_t           state;
  iscp_state_t           next_state;
  iscp_mode_t            mode;
  iscp_mode_t            next_mode;
  logic                  pend_maint;
  logic                  next_pend_maint;
  logic                  pend_trim;
  logic                  next_pend_trim;
  logic [`ISCP_LEN_W-1:0] len;
  logic [`ISCP_LEN_W-1:0] next_len;
  logic [7:0]            rx_char;
  logic [7:0]            next_rx_char;
  iscp_msg_t             msg_sel;
  iscp_msg_t             next_msg_sel;
  logic [`ISCP_IDX_W-1:0] msg_idx;
  logic [`ISCP_IDX_W-1:0] next_msg_idx;
  iscp_special_t         spec_pend;
  iscp_special_t         next_spec_pend;
  logic                  spec_active;
  logic                  next_spec_active;
  iscp_dgram_t           spec_kind;
  iscp_dgram_t           next_spec_kind;
  iscp_special_t         next_special;
  iscp_cmd_t             next_cmd;
  logic                  next_unit_reset;
  logic                  next_err_clear;
  logic                  next_listing;
  logic                  next_rx_ready;
  logic                  next_tx_valid;
  logic [7:0]            next_tx_data;
  logic                  mem_we;
  logic                  push;
  logic [7:0]            push_data;
  logic                  in_ready;
  logic                  f_valid;
  logic [7:0]            f_data;
  logic                  pop;
  logic                  acc;
  logic                  slot;
  logic                  trig_meta;
  logic                  trig_sync;
  logic                  trig_prev;
  logic [87:0]           head;
  logic [7:0]            last_push;

  function automatic logic [5:0] msg_tlen(input iscp_msg_t s);
    case (s)
      ISCP_MSG_E001: msg_tlen = `ISCP_E001_LEN;
      ISCP_MSG_E002: msg_tlen = `ISCP_E002_LEN;
      default:       msg_tlen = '0;
    endcase
  endfunction

  // Error text, then CR ending the error line, then the CR '>' prompt
  function automatic logic [7:0] msg_byte(input iscp_msg_t s, input logic [5:0] i);
    logic [279:0] t;
    logic [5:0]   n;
    t = '0;
    n = msg_tlen(s);
    case (s)
      ISCP_MSG_E001: t = 280'(`ISCP_E001_TXT);
      ISCP_MSG_E002: t = 280'(`ISCP_E002_TXT);
      default:       t = '0;
    endcase
    if (i < n) begin
      msg_byte = t[8*(int'(n)-1-int'(i)) +: 8];
    end else if (i == n + `ISCP_TAIL_LEN) begin
      msg_byte = `ISCP_CH_GT;
    end else begin
      msg_byte = `ISCP_CH_CR;
    end
  endfunction

  function automatic logic word_hit(input logic [87:0] h, input logic [6:0] l,
                                    input logic [87:0] w, input int n);
    word_hit = (int'(l) == n) && ((h >> (8*(`ISCP_NRM_MAX-n))) == w);
  endfunction

  function automatic logic maint_known(input logic [7:0] c);
    case (c)
      "i", "a", "c", "d", "t", "r", "u", "f",
      "m", "g", "b", "s", "x", "z", "?": maint_known = 1'b1;
      default: maint_known = 1'b0;
    endcase
  endfunction

  iscp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push),
    .in_data_i   (push_data),
    .in_ready_o  (in_ready),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (!tx_valid_o || tx_ready_i)
  );

  assign mode_o = mode;
  assign acc    = rx_valid_i && rx_ready_o;
  assign slot   = ext_trig_mode_i ? (trig_sync && !trig_prev) : slot_i;
  assign pop    = f_valid && (!tx_valid_o || tx_ready_i);

  always_comb begin
    for (int k = 0; k < `ISCP_NRM_MAX; k++) begin
      head[87-8*k -: 8] = mem[k];
    end
  end

  always_comb begin
    next_state       = state;
    next_mode        = mode;
    next_pend_maint  = pend_maint;
    next_pend_trim   = pend_trim;
    next_len         = len;
    next_rx_char     = rx_char;
    next_msg_sel     = msg_sel;
    next_msg_idx     = msg_idx;
    next_spec_pend   = spec_pend;
    next_spec_active = spec_active;
    next_spec_kind   = spec_kind;
    next_special     = '0;
    next_cmd         = '0;
    next_unit_reset  = 1'b0;
    next_err_clear   = startup_done_i;
    next_listing     = 1'b0;
    mem_we           = 1'b0;
    push             = 1'b0;
    push_data        = rx_char;
    // Busy special datagram swallows further slots until it ends
    if (spec_active && dgram_done_i) begin
      next_spec_active = 1'b0;
      if (spec_kind == ISCP_DG_ERROR) begin
        next_err_clear = 1'b1;
      end
    end else if (!spec_active && spec_pend.valid && slot) begin
      next_special         = spec_pend;
      next_spec_active     = 1'b1;
      next_spec_kind       = spec_pend.kind;
      next_spec_pend.valid = 1'b0;
    end
    if (mode == ISCP_MODE_MAINT && maint_exit_i) begin
      next_mode = ISCP_MODE_NORMAL;
    end
    if (mode == ISCP_MODE_TRIM && trim_exit_i) begin
      next_mode = ISCP_MODE_NORMAL;
    end
    case (state)
      ISCP_ST_IDLE: begin
        if (pend_maint && !dgram_busy_i) begin
          next_pend_maint = 1'b0;
          next_mode       = ISCP_MODE_MAINT;
          next_listing    = 1'b1;
          next_state      = ISCP_ST_LIST;
        end else if (pend_trim && !dgram_busy_i) begin
          next_pend_trim = 1'b0;
          next_mode      = ISCP_MODE_TRIM;
        end else if (acc) begin
          next_rx_char = rx_data_i;
          if (mode == ISCP_MODE_MAINT) begin
            next_state = ISCP_ST_ECHO;
            if (rx_data_i == `ISCP_CH_BS) begin
              if (len != '0) begin
                next_len = len - 1'b1;
              end
            end else if (rx_data_i != `ISCP_CH_CR && int'(len) < LINE_LEN) begin
              mem_we   = 1'b1;
              next_len = len + 1'b1;
            end
          end else if (mode == ISCP_MODE_NORMAL) begin
            if (rx_data_i == `ISCP_CH_CR) begin
              next_state = ISCP_ST_DECODE;
            end else if (int'(len) < LINE_LEN) begin
              mem_we   = 1'b1;
              next_len = len + 1'b1;
            end
          end
        end
      end
      ISCP_ST_ECHO: begin
        push = 1'b1;
        if (in_ready) begin
          next_state = (rx_char == `ISCP_CH_CR) ? ISCP_ST_DECODE : ISCP_ST_IDLE;
        end
      end
      ISCP_ST_DECODE: begin
        next_len = '0;
        if (mode == ISCP_MODE_MAINT) begin
          next_state   = ISCP_ST_MSG;
          next_msg_sel = ISCP_MSG_PROMPT;
          next_msg_idx = '0;
          if (len == '0) begin
            next_msg_idx = `ISCP_PROMPT_START;
          end else if (!maint_known(mem[0])) begin
            next_msg_sel = ISCP_MSG_E001;
          end else if (len > 7'h01 && mem[1] == `ISCP_CH_COMMA) begin
            next_msg_sel = ISCP_MSG_E002;
          end else if (len > 7'h01 && mem[1] != `ISCP_CH_SP) begin
            next_msg_sel = ISCP_MSG_E001;
          end else begin
            next_msg_idx = `ISCP_PROMPT_START;
            next_cmd     = '{valid: 1'b1, letter: mem[0], len: len};
            if (mem[0] == "i" && len == 7'h03 && mem[2] == "e") begin
              next_err_clear = 1'b1;
            end
          end
        end else begin
          next_state = ISCP_ST_IDLE;
          if (word_hit(head, len, 88'("C"), 1)) begin
            next_spec_pend = '{valid: 1'b1, kind: ISCP_DG_CONFIG};
          end else if (word_hit(head, len, 88'("T"), 1)) begin
            next_spec_pend = '{valid: 1'b1, kind: ISCP_DG_TRIM};
          end else if (word_hit(head, len, 88'("E"), 1)) begin
            next_spec_pend = '{valid: 1'b1, kind: ISCP_DG_ERROR};
          end else if (word_hit(head, len, 88'("R"), 1)) begin
            next_unit_reset = 1'b1;
          end else if (word_hit(head, len, 88'(`ISCP_MAINT_WORD), `ISCP_MAINT_WLEN)) begin
            next_pend_maint = 1'b1;
          end else if (word_hit(head, len, 88'(`ISCP_TRIM_WORD), `ISCP_TRIM_WLEN)) begin
            next_pend_trim = 1'b1;
          end
        end
      end
      ISCP_ST_MSG: begin
        push      = 1'b1;
        push_data = msg_byte(msg_sel, msg_idx);
        if (in_ready) begin
          if (msg_idx == msg_tlen(msg_sel) + `ISCP_TAIL_LEN) begin
            next_state = ISCP_ST_IDLE;
          end else begin
            next_msg_idx = msg_idx + 1'b1;
          end
        end
      end
      ISCP_ST_LIST: begin
        // The listing text itself comes from outside; prompt follows it
        if (listing_done_i) begin
          next_state   = ISCP_ST_MSG;
          next_msg_sel = ISCP_MSG_PROMPT;
          next_msg_idx = `ISCP_PROMPT_START;
        end
      end
      default: next_state = ISCP_ST_IDLE;
    endcase
    next_rx_ready = (next_state == ISCP_ST_IDLE) && !next_pend_maint && !next_pend_trim;
    next_tx_valid = tx_valid_o && !tx_ready_i;
    next_tx_data  = tx_data_o;
    if (pop) begin
      next_tx_valid = 1'b1;
      next_tx_data  = f_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state           <= ISCP_ST_IDLE;
      mode            <= ISCP_MODE_NORMAL;
      pend_maint      <= 1'b0;
      pend_trim       <= 1'b0;
      len             <= '0;
      rx_char         <= 8'h00;
      msg_sel         <= ISCP_MSG_PROMPT;
      msg_idx         <= '0;
      spec_pend       <= '0;
      spec_active     <= 1'b0;
      spec_kind       <= ISCP_DG_CONFIG;
      special_o       <= '0;
      maint_cmd_o     <= '0;
      unit_reset_o    <= 1'b0;
      err_clear_o     <= 1'b0;
      listing_start_o <= 1'b0;
      rx_ready_o      <= 1'b0;
      tx_valid_o      <= 1'b0;
      tx_data_o       <= 8'h00;
      trig_meta       <= 1'b0;
      trig_sync       <= 1'b0;
      trig_prev       <= 1'b0;
      last_push       <= 8'h00;
    end else begin
      state           <= next_state;
      mode            <= next_mode;
      pend_maint      <= next_pend_maint;
      pend_trim       <= next_pend_trim;
      len             <= next_len;
      rx_char         <= next_rx_char;
      msg_sel         <= next_msg_sel;
      msg_idx         <= next_msg_idx;
      spec_pend       <= next_spec_pend;
      spec_active     <= next_spec_active;
      spec_kind       <= next_spec_kind;
      special_o       <= next_special;
      maint_cmd_o     <= next_cmd;
      unit_reset_o    <= next_unit_reset;
      err_clear_o     <= next_err_clear;
      listing_start_o <= next_listing;
      rx_ready_o      <= next_rx_ready;
      tx_valid_o      <= next_tx_valid;
      tx_data_o       <= next_tx_data;
      trig_meta       <= ext_trig_i;
      trig_sync       <= trig_meta;
      trig_prev       <= trig_sync;
      if (push && in_ready) begin
        last_push <= push_data;
      end
    end
    if (mem_we) begin
      mem[len] <= rx_data_i;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_maint_char;
    acc && mode == ISCP_MODE_MAINT;
  endsequence
  sequence s_done_err;
    spec_active && dgram_done_i && spec_kind == ISCP_DG_ERROR;
  endsequence

  property p_special_slot;
    special_o.valid |-> $past(slot && spec_pend.valid && !spec_active);
  endproperty
  a_special_slot: assert property (p_special_slot) else $error("special without slot");
  property p_one_active;
    spec_active && !dgram_done_i |=> !special_o.valid;
  endproperty
  a_one_active: assert property (p_one_active) else $error("slot taken twice");
  property p_err_clear;
    s_done_err |=> err_clear_o;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("errors not cleared");
  property p_maint_wait;
    $rose(mode == ISCP_MODE_MAINT) |-> $past(!dgram_busy_i) && listing_start_o;
  endproperty
  a_maint_wait: assert property (p_maint_wait) else $error("bad maintenance entry");
  property p_trim_wait;
    $rose(mode == ISCP_MODE_TRIM) |-> $past(!dgram_busy_i);
  endproperty
  a_trim_wait: assert property (p_trim_wait) else $error("trim entry mid datagram");
  property p_prompt;
    // Only generated prompts count; an echoed '>' typed by the host is legal
    state == ISCP_ST_MSG && push && in_ready && push_data == `ISCP_CH_GT
      |-> last_push == `ISCP_CH_CR;
  endproperty
  a_prompt: assert property (p_prompt) else $error("prompt without CR");
  property p_echo;
    s_maint_char |=> state == ISCP_ST_ECHO && push_data == $past(rx_data_i);
  endproperty
  a_echo: assert property (p_echo) else $error("char not echoed");
  property p_cmd_cr;
    maint_cmd_o.valid |-> $past(state == ISCP_ST_DECODE) && $past(rx_char, 2) == `ISCP_CH_CR;
  endproperty
  a_cmd_cr: assert property (p_cmd_cr) else $error("decode without CR");
  property p_bs;
    s_maint_char ##0 (rx_data_i == `ISCP_CH_BS && len != '0) |=> len == $past(len) - 1'b1;
  endproperty
  a_bs: assert property (p_bs) else $error("back-space failed");
  property p_len;
    int'(len) <= LINE_LEN;
  endproperty
  a_len: assert property (p_len) else $error("line overflow");
  property p_err_e;
    state == ISCP_ST_MSG && msg_sel != ISCP_MSG_PROMPT && msg_idx == '0 |-> push_data == "E";
  endproperty
  a_err_e: assert property (p_err_e) else $error("error line format");
  property p_quiet;
    mode == ISCP_MODE_NORMAL |-> !push;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output in normal mode");
endmodule

//--- sim/iscp_host_model.sv
`timescale 1ns/1ps
module iscp_host_model (
  input  logic       clock_i,
  input  logic       rx_ready_i,
  input  logic [1:0] tx_mode_i,
  output logic       rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic       tx_ready_o,
  output logic       hang_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b0;
    hang_o     = 1'b0;
  end
  // Mode 0 takes every byte, 1 stalls at random, 2 stops so the buffer fills
  always @(posedge clock_i) begin
    tx_ready_o <= (tx_mode_i == 2'h0) || (tx_mode_i == 2'h1 && $urandom_range(3) == 0);
  end
  // Called at a rising edge; each byte stands until the edge that takes it
  task automatic send_line(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= s[i];
      n = 0;
      do begin
        @(posedge clock_i);
        n++;
      end while (rx_ready_i !== 1'b1 && n < 2000);
      if (n >= 2000) hang_o <= 1'b1;
    end
    rx_valid_o <= 1'b0;
    // Released data flips so a stale byte never looks valid
    rx_data_o  <= ~rx_data_o;
    // One idle edge, so a following call never drives valid in this time step
    @(posedge clock_i);
  endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "iscp_defines.svh"
module tb_top
  import iscp_pkg::*;
;
  localparam int SLOT  = 4;
  localparam int STUP  = 3;
  localparam int MEXIT = 2;
  localparam int TEXIT = 1;
  localparam int TRIG  = 0;
  logic          clock_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
  logic [7:0]    rx_data_i, tx_data_o;
  logic [4:0]    pls = 5'h00;
  logic          slot_i, startup_done_i, maint_exit_i, trim_exit_i, ext_trig_i;
  logic          ext_trig_mode_i = 1'b0;
  logic          dgram_busy_i = 1'b0;
  logic          dgram_done_i = 1'b0;
  logic          listing_done_i = 1'b0;
  logic          unit_reset_o, err_clear_o, listing_start_o;
  iscp_special_t special_o;
  iscp_mode_t    mode_o;
  iscp_cmd_t     maint_cmd_o;
  logic [1:0]    tx_mode = 2'h0;
  logic          hang;
  int            miscompares = 0;
  int            samples_checked = 0;
  int            bcnt = 0;
  int            lcnt = 0;
  string         cr = "\015";
  string         bs = "\010";
  logic [7:0]    exp_tx[$];
  logic [15:0]   exp_ev[6][$];

  assign {slot_i, startup_done_i, maint_exit_i, trim_exit_i, ext_trig_i} = pls;
  always #10 clock_i = ~clock_i;

  iscp_top #(.LINE_LEN(80), .FIFO_DEPTH(`ISCP_FIFO_DEPTH)) dut (
    .clock_i, .sys_rst_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o, .tx_data_o,
    .tx_ready_i, .slot_i, .ext_trig_mode_i, .ext_trig_i, .dgram_busy_i, .dgram_done_i,
    .startup_done_i, .listing_done_i, .maint_exit_i, .trim_exit_i, .special_o, .mode_o,
    .unit_reset_o, .err_clear_o, .listing_start_o, .maint_cmd_o);

  iscp_host_model host (
    .clock_i, .rx_ready_i(rx_ready_o), .tx_mode_i(tx_mode), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i), .hang_o(hang));

  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic pulse(input int b, input int n);
    pls[b] <= 1'b1;
    tick(n);
    pls[b] <= 1'b0;
    tick(1);
  endtask

  task automatic note(input int k, input logic [15:0] d);
    exp_ev[k].push_back(d);
  endtask

  task automatic note_str(input string s);
    foreach (s[i]) exp_tx.push_back(s[i]);
  endtask

  task automatic cmp_tx(input logic [7:0] got);
    logic [7:0] e;
    e = (exp_tx.size() != 0) ? exp_tx.pop_front() : 8'hxx;
    samples_checked++;
    if (e !== got) begin
      miscompares++;
      $display("CHECK FAILED tx_data_o expected %h seen %h", e, got);
    end
  endtask

  task automatic cmp_ev(input int k, input logic [15:0] got);
    logic [15:0] e;
    e = (exp_ev[k].size() != 0) ? exp_ev[k].pop_front() : 16'hxxxx;
    samples_checked++;
    if (e !== got) begin
      miscompares++;
      $display("CHECK FAILED event %0d expected %h seen %h", k, e, got);
    end
  endtask

  task automatic cmp_flag(input string nm, input logic e, input logic got);
    samples_checked++;
    if (e !== got) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, got);
    end
  endtask

  function automatic int pending();
    int n;
    n = exp_tx.size();
    foreach (exp_ev[k]) n += exp_ev[k].size();
    return n;
  endfunction

  // Bounded wait until every noted result has been seen
  task automatic drain();
    int n;
    n = 0;
    while (pending() != 0 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      $display("CHECK FAILED pending expected 0 seen %0d", pending());
      stop_test();
    end
  endtask

  task automatic maint(input string s, input string reply);
    note_str({s, cr, reply, cr, ">"});
    host.send_line({s, cr});
    drain();
  endtask

  // Datagram and listing senders live outside the block; busy outlasts a slot gap
  always @(posedge clock_i) begin
    dgram_done_i   <= (bcnt == 1);
    dgram_busy_i   <= (bcnt > 1);
    listing_done_i <= (lcnt == 1);
    if (special_o.valid === 1'b1) bcnt <= 100;
    else if (bcnt > 0) bcnt <= bcnt - 1;
    if (listing_start_o === 1'b1) lcnt <= 12;
    else if (lcnt > 0) lcnt <= lcnt - 1;
  end

  // One queue per kind, so order across kinds does not matter
  always @(posedge clock_i) begin
    if (!sys_rst_i) begin
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) cmp_tx(tx_data_o);
      if (special_o.valid === 1'b1) cmp_ev(1, {13'h0000, special_o});
      if (maint_cmd_o.valid === 1'b1) cmp_ev(2, maint_cmd_o);
      if (listing_start_o === 1'b1) cmp_ev(3, 16'h0000);
      if (unit_reset_o === 1'b1) cmp_ev(4, 16'h0000);
      if (err_clear_o === 1'b1) cmp_ev(5, 16'h0000);
    end
  end

  always @(posedge clock_i) begin
    if (hang === 1'b1) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    tick(100000);
    miscompares++;
    stop_test();
  end

  initial begin
    string s;
    string c;
    string ltr;
    void'($urandom(32'h0f00049f));
    c = " ";
    ltr = "iacdtrufmgbsxz?";
    tick(16);
    sys_rst_i <= 1'b0;
    tick(2);
    note(5, 16'h0000);
    pulse(STUP, 1);
    note(1, {13'h0000, 1'b1, ISCP_DG_CONFIG});
    host.send_line({"X", cr});
    host.send_line({"c", cr});
    host.send_line({"C", cr});
    pulse(SLOT, 1);
    tick(5);
    pulse(SLOT, 1);
    host.send_line({"T", cr});
    pulse(SLOT, 1);
    tick(120);
    drain();
    ext_trig_mode_i <= 1'b1;
    note(1, {13'h0000, 1'b1, ISCP_DG_TRIM});
    pulse(TRIG, 5);
    tick(120);
    ext_trig_mode_i <= 1'b0;
    note(1, {13'h0000, 1'b1, ISCP_DG_ERROR});
    note(5, 16'h0000);
    host.send_line({"E", cr});
    pulse(SLOT, 1);
    tick(120);
    drain();
    note(4, 16'h0000);
    host.send_line({"R", cr});
    drain();
    sys_rst_i <= 1'b1;
    tick(4);
    sys_rst_i <= 1'b0;
    tick(2);
    note(5, 16'h0000);
    pulse(STUP, 1);
    note(1, {13'h0000, 1'b1, ISCP_DG_CONFIG});
    host.send_line({"C", cr});
    pulse(SLOT, 1);
    tick(3);
    host.send_line({$sformatf("%s", `ISCP_MAINT_WORD), cr});
    cmp_flag("mode_o_normal", 1'b1, mode_o === ISCP_MODE_NORMAL);
    note(3, 16'h0000);
    note_str({cr, ">"});
    tick(130);
    drain();
    cmp_flag("mode_o_maint", 1'b1, mode_o === ISCP_MODE_MAINT);
    foreach (ltr[i]) begin
      c[0] = ltr[i];
      note(2, {1'b1, ltr[i], 7'h01});
      maint(c, "");
    end
    maint("I", {`ISCP_E001_TXT, cr});
    maint("i,e", {`ISCP_E002_TXT, cr});
    note(2, {1'b1, 8'h69, 7'h03});
    note(5, 16'h0000);
    maint("i e", "");
    note(2, {1'b1, 8'h69, 7'h01});
    maint({"q", bs, "i"}, "");
    note(2, {1'b1, 8'h64, 7'h01});
    maint({bs, "d"}, "");
    maint("", "");
    s = "b ";
    for (int i = 0; i < 83; i++) begin
      c[0] = 8'h61 + 8'($urandom_range(25));
      s = {s, c};
    end
    tx_mode <= 2'h1;
    note(2, {1'b1, 8'h62, 7'h50});
    maint(s, "");
    tx_mode <= 2'h2;
    note_str("abcdefghijklmnopqrst");
    fork
      host.send_line("abcdefghijklmnopqrst");
      begin
        tick(200);
        cmp_flag("rx_ready_o", 1'b0, rx_ready_o);
        tx_mode <= 2'h0;
      end
    join
    maint("", {`ISCP_E001_TXT, cr});
    pulse(MEXIT, 1);
    tick(3);
    cmp_flag("mode_o_exit", 1'b1, mode_o === ISCP_MODE_NORMAL);
    note(1, {13'h0000, 1'b1, ISCP_DG_CONFIG});
    host.send_line({"C", cr});
    pulse(SLOT, 1);
    tick(3);
    host.send_line({$sformatf("%s", `ISCP_TRIM_WORD), cr});
    cmp_flag("mode_o_wait", 1'b1, mode_o === ISCP_MODE_NORMAL);
    tick(130);
    cmp_flag("mode_o_trim", 1'b1, mode_o === ISCP_MODE_TRIM);
    host.send_line({"i e", cr});
    tick(20);
    pulse(TEXIT, 1);
    tick(3);
    cmp_flag("mode_o_back", 1'b1, mode_o === ISCP_MODE_NORMAL);
    drain();
    stop_test();
  end
endmodule
